// ---- core/hut_uart.sv ----
// HCI UART transport: rate generator, framer, queues, AXI4-Lite regs.
// Assumes pins synchronous to clock_in; firmware runs the HCI commands.
//
// What this block does
// - Four-wire port, 9600 bps to 4.0 Mbps
// - Detect line rate, report chosen setting
// - Host command may set rate instead
// - Separate 1040-byte receive and transmit queues
// - Queues reachable from internal bus
// - Support H4, extended H4 and H5
// - Default rate 115.2 Kbaud after reset
// - H5 ignores request line; clear line only wakes sleep
// - XOFF pauses, XON resumes transmission
// - SLIP delimiting and escaping in hardware
// - Receive or clear activity wakes sleep
// - Rate from loaded record or detection
// - Rate registers rewritable without reset
// - Combined rate error within two percent
// - Rate table maps requested to actual
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module hut_uart
	import hut_pkg::*;
#(
	parameter int QDEPTH = 1040,
	parameter int RTS_HI = 1008,
	parameter int RTS_LO = 976
)(
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic uart_rx_in,
	output logic uart_tx_out,
	input wire logic uart_cts_n_in,
	output logic uart_rts_n_out
);
	localparam int LW = $clog2(QDEPTH + 1);

	// ****************
	// Functions
	// ****************
	function automatic logic [31:0] apply_strb(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction

	function automatic logic [31:0] map_rate(input logic [31:0] req);
		logic [31:0] r;
		r = (req < HUT_RATE_MIN) ? HUT_RATE_MIN :
			(req > HUT_RATE_MAX) ? HUT_RATE_MAX : req;
		for (int i = 0; i < 16; i++)
			if (req == HUT_RATE_REQ[i])
				r = HUT_RATE_ACT[i];
		return r;
	endfunction

	// Nearest table rate to one measured bit time
	function automatic logic [3:0] pick_index(input logic [15:0] cnt);
		logic [47:0] prod;
		logic [47:0] err;
		logic [47:0] best;
		logic [3:0] idx;
		best = '1;
		idx = '0;
		for (int i = 0; i < 16; i++)
		begin
			prod = 48'(cnt) * 48'(HUT_RATE_ACT[i]);
			err = (prod > 48'(HUT_CLK_HZ)) ? prod - 48'(HUT_CLK_HZ) :
				48'(HUT_CLK_HZ) - prod;
			if (err < best)
			begin
				best = err;
				idx = 4'(i);
			end
		end
		return idx;
	endfunction

	// ****************
	// Queues
	// ****************
	hut_fifo_if #(.W(9), .LW(2)) rxb ();
	hut_fifo_if #(.W(9), .LW(LW)) rxq ();
	hut_fifo_if #(.W(9), .LW(LW)) txq ();

	// Two-entry buffer absorbs a stall of the big queue
	hut_fifo #(.W(9), .DEPTH(2), .LW(2)) u_rx_buf (
		.clock_in(clock_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.q(rxb)
	);
	hut_fifo #(.W(9), .DEPTH(QDEPTH), .LW(LW)) u_rx_q (
		.clock_in(clock_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.q(rxq)
	);
	hut_fifo #(.W(9), .DEPTH(QDEPTH), .LW(LW)) u_tx_q (
		.clock_in(clock_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.q(txq)
	);
	assign rxq.wdata = rxb.rdata;
	assign rxq.wvalid = rxb.rvalid;
	assign rxb.rready = rxq.wready;

	// ****************
	// Register bus
	// ****************
	logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff, rd_val;
	logic [3:0] wstrb_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic do_wr, do_rd, rd_ok, wr_ok;
	hut_mode_t mode_ff;
	logic xon_en_ff, slip_en_ff, ab_arm_ff, sleep_ff, xoff_ff;
	logic ab_done_ff, wake_ff, ovr_ff;
	logic [3:0] ab_idx_ff;
	logic [31:0] rate_ff, ctrl_rd;

	assign s_axi_awready_out = clk_en_in && !aw_held_ff;
	assign s_axi_wready_out = clk_en_in && !w_held_ff;
	assign s_axi_arready_out = clk_en_in && !rvalid_ff;
	assign s_axi_bvalid_out = bvalid_ff;
	assign s_axi_bresp_out = bresp_ff;
	assign s_axi_rvalid_out = rvalid_ff;
	assign s_axi_rdata_out = rdata_ff;
	assign s_axi_rresp_out = rresp_ff;
	assign do_wr = clk_en_in && aw_held_ff && w_held_ff && !bvalid_ff;
	assign do_rd = s_axi_arvalid_in && s_axi_arready_out;
	assign wr_ok = (awaddr_ff <= HUT_OFF_LVL) && (awaddr_ff[1:0] == 2'h0);
	assign ctrl_rd = {26'h0, sleep_ff, ab_arm_ff, slip_en_ff, xon_en_ff,
		mode_ff};

	always_comb
	begin
		rd_ok = 1'b1;
		case (s_axi_araddr_in)
			HUT_OFF_CTRL: rd_val = ctrl_rd;
			HUT_OFF_RATE: rd_val = rate_ff;
			HUT_OFF_STAT: rd_val = {20'h0, ab_idx_ff, 1'b0, ovr_ff, wake_ff,
				sleep_ff, ab_done_ff, xoff_ff, !rxq.rvalid, !txq.wready};
			HUT_OFF_TXD: rd_val = 32'h0;
			HUT_OFF_RXD: rd_val = {rxq.rvalid, 22'h0, rxq.rdata};
			HUT_OFF_LVL: rd_val = {16'(txq.level), 16'(rxq.level)};
			default:
			begin
				rd_val = 32'h0;
				rd_ok = 1'b0;
			end
		endcase
	end
	// Reading the receive data word pops it
	assign rxq.rready = do_rd && (s_axi_araddr_in == HUT_OFF_RXD);
	assign txq.wvalid = do_wr && (awaddr_ff == HUT_OFF_TXD) &&
		wstrb_ff[0];
	assign txq.wdata = wdata_ff[8:0];

	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= HUT_RESP_OKAY;
			awaddr_ff <= 8'h0;
			wdata_ff <= 32'h0;
			wstrb_ff <= 4'h0;
		end
		else if (clk_en_in)
		begin
			if (s_axi_awvalid_in && !aw_held_ff)
			begin
				aw_held_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr_in;
			end
			if (s_axi_wvalid_in && !w_held_ff)
			begin
				w_held_ff <= 1'b1;
				wdata_ff <= s_axi_wdata_in;
				wstrb_ff <= s_axi_wstrb_in;
			end
			if (do_wr)
			begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_ok ? HUT_RESP_OKAY : HUT_RESP_SLVERR;
			end
			else if (bvalid_ff && s_axi_bready_in)
				bvalid_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rresp_ff <= HUT_RESP_OKAY;
		end
		else if (clk_en_in)
		begin
			if (do_rd)
			begin
				rvalid_ff <= 1'b1;
				rdata_ff <= rd_val;
				rresp_ff <= rd_ok ? HUT_RESP_OKAY : HUT_RESP_SLVERR;
			end
			else if (s_axi_rready_in)
				rvalid_ff <= 1'b0;
		end
	end

	// ****************
	// Control and rate
	// ****************
	logic wr_ctrl, wr_rate, wr_stat, ab_hit, wake_ev, cts_prev_ff;
	logic [31:0] nxt_ctrl;
	logic [15:0] ab_cnt_ff;
	logic ab_meas_ff;
	assign wr_ctrl = do_wr && (awaddr_ff == HUT_OFF_CTRL);
	assign wr_rate = do_wr && (awaddr_ff == HUT_OFF_RATE);
	assign wr_stat = do_wr && (awaddr_ff == HUT_OFF_STAT);
	assign nxt_ctrl = apply_strb(ctrl_rd, wdata_ff, wstrb_ff);
	assign ab_hit = ab_meas_ff && uart_rx_in;
	assign wake_ev = sleep_ff && (!uart_rx_in ||
		(uart_cts_n_in != cts_prev_ff));

	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			mode_ff <= HUT_H4;
			xon_en_ff <= 1'b0;
			slip_en_ff <= 1'b0;
		end
		else if (clk_en_in && wr_ctrl)
		begin
			mode_ff <= (nxt_ctrl[1:0] == 2'b11) ? HUT_H4 :
				hut_mode_t'(nxt_ctrl[1:0]);
			xon_en_ff <= nxt_ctrl[HUT_CTRL_XON];
			slip_en_ff <= nxt_ctrl[HUT_CTRL_SLIP];
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
			rate_ff <= HUT_RATE_RESET;
		else if (clk_en_in && ab_hit)
			rate_ff <= HUT_RATE_ACT[pick_index(ab_cnt_ff)];
		else if (clk_en_in && wr_rate)
			rate_ff <= map_rate(apply_strb(rate_ff, wdata_ff,
				wstrb_ff));
	end

	// Detection times the low start bit of the first byte
	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			ab_arm_ff <= 1'b0;
			ab_meas_ff <= 1'b0;
			ab_cnt_ff <= 16'h0;
			ab_idx_ff <= 4'h0;
			ab_done_ff <= 1'b0;
		end
		else if (clk_en_in)
		begin
			if (ab_hit)
			begin
				ab_arm_ff <= 1'b0;
				ab_meas_ff <= 1'b0;
				ab_idx_ff <= pick_index(ab_cnt_ff);
				ab_done_ff <= 1'b1;
			end
			else if (ab_arm_ff && !uart_rx_in)
			begin
				ab_meas_ff <= 1'b1;
				ab_cnt_ff <= (ab_cnt_ff == 16'hffff) ? ab_cnt_ff :
					ab_cnt_ff + 16'h1;
			end
			else if (wr_ctrl && nxt_ctrl[HUT_CTRL_AB])
			begin
				ab_arm_ff <= 1'b1;
				ab_cnt_ff <= 16'h0;
				ab_done_ff <= 1'b0;
			end
			else if (wr_stat && wdata_ff[HUT_STAT_AB])
				ab_done_ff <= 1'b0;
		end
	end

	// Sticky flags: a new event beats a clear in the same cycle
	logic rx_ovr_ev;
	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			sleep_ff <= 1'b0;
			wake_ff <= 1'b0;
			ovr_ff <= 1'b0;
			cts_prev_ff <= 1'b1;
		end
		else if (clk_en_in)
		begin
			cts_prev_ff <= uart_cts_n_in;
			if (wake_ev)
				sleep_ff <= 1'b0;
			else if (wr_ctrl && nxt_ctrl[HUT_CTRL_SLEEP])
				sleep_ff <= 1'b1;
			if (wake_ev)
				wake_ff <= 1'b1;
			else if (wr_stat && wdata_ff[HUT_STAT_WAKE])
				wake_ff <= 1'b0;
			if (rx_ovr_ev)
				ovr_ff <= 1'b1;
			else if (wr_stat && wdata_ff[HUT_STAT_OVR])
				ovr_ff <= 1'b0;
		end
	end

	// ****************
	// Rate generator
	// ****************
	// Fractional accumulator: average tick rate is exactly 16x rate_ff
	logic [31:0] acc_ff;
	logic [32:0] acc_sum;
	logic tick;
	assign acc_sum = {1'b0, acc_ff} + {1'b0, rate_ff[27:0], 4'h0};
	assign tick = clk_en_in && (acc_sum >= {1'b0, HUT_CLK_HZ});

	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
			acc_ff <= 32'h0;
		else if (clk_en_in)
			acc_ff <= tick ? 32'(acc_sum - {1'b0, HUT_CLK_HZ}) :
				acc_sum[31:0];
	end

	// ****************
	// Receiver
	// ****************
	hut_state_t rx_st_ff;
	logic [3:0] rx_sub_ff;
	logic [2:0] rx_bit_ff;
	logic [7:0] rx_sh_ff;
	logic rx_done_ff, esc_ff, push_v, nxt_esc, nxt_xoff, slip_on;
	logic [8:0] push_d;
	assign slip_on = (mode_ff == HUT_H5) && slip_en_ff;

	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			rx_st_ff <= HUT_S_IDLE;
			rx_sub_ff <= 4'h0;
			rx_bit_ff <= 3'h0;
			rx_sh_ff <= 8'h0;
			rx_done_ff <= 1'b0;
		end
		else if (clk_en_in)
		begin
			rx_done_ff <= 1'b0;
			if (tick)
			begin
				rx_sub_ff <= rx_sub_ff + 4'h1;
				case (rx_st_ff)
					HUT_S_IDLE:
					begin
						rx_sub_ff <= 4'h0;
						if (!uart_rx_in && !ab_arm_ff && !sleep_ff)
							rx_st_ff <= HUT_S_START;
					end
					HUT_S_START:
						if (rx_sub_ff == HUT_OSR_MID)
						begin
							rx_sub_ff <= 4'h0;
							rx_bit_ff <= 3'h0;
							rx_st_ff <= uart_rx_in ? HUT_S_IDLE : HUT_S_DATA;
						end
					HUT_S_DATA:
						if (rx_sub_ff == HUT_OSR_LAST)
						begin
							rx_sh_ff <= {uart_rx_in, rx_sh_ff[7:1]};
							rx_bit_ff <= rx_bit_ff + 3'h1;
							if (rx_bit_ff == 3'h7)
								rx_st_ff <= HUT_S_STOP;
						end
					HUT_S_STOP:
						if (rx_sub_ff == HUT_OSR_LAST)
						begin
							rx_st_ff <= HUT_S_IDLE;
							rx_done_ff <= uart_rx_in;
						end
					default: rx_st_ff <= HUT_S_IDLE;
				endcase
			end
		end
	end

	always_comb
	begin
		push_v = 1'b0;
		push_d = 9'h0;
		nxt_esc = esc_ff;
		nxt_xoff = xoff_ff && xon_en_ff;
		if (rx_done_ff)
		begin
			if (xon_en_ff && rx_sh_ff == HUT_XOFF)
				nxt_xoff = 1'b1;
			else if (xon_en_ff && rx_sh_ff == HUT_XON)
				nxt_xoff = 1'b0;
			else if (slip_on && esc_ff)
			begin
				nxt_esc = 1'b0;
				push_v = 1'b1;
				push_d = {1'b0, (rx_sh_ff == HUT_ESC_END) ? HUT_SLIP_END :
					(rx_sh_ff == HUT_ESC_ESC) ? HUT_SLIP_ESC :
					rx_sh_ff};
			end
			else if (slip_on && rx_sh_ff == HUT_SLIP_ESC)
				nxt_esc = 1'b1;
			else
			begin
				push_v = 1'b1;
				push_d = {slip_on && rx_sh_ff == HUT_SLIP_END, rx_sh_ff};
			end
		end
	end
	assign rxb.wvalid = push_v;
	assign rxb.wdata = push_d;
	// No way to stall the wire: a refused byte is counted as overrun
	assign rx_ovr_ev = push_v && !rxb.wready;

	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			esc_ff <= 1'b0;
			xoff_ff <= 1'b0;
		end
		else if (clk_en_in)
		begin
			esc_ff <= nxt_esc && slip_on;
			xoff_ff <= nxt_xoff;
		end
	end

	// ****************
	// Transmitter and flow lines
	// ****************
	hut_state_t tx_st_ff;
	logic [3:0] tx_sub_ff;
	logic [2:0] tx_bit_ff;
	logic [7:0] tx_sh_ff, pend_b_ff, enc_b, enc_p;
	logic pend_ff, enc_pv, can_send, tx_line_ff, rts_n_ff;
	assign can_send = !sleep_ff && !xoff_ff &&
		((mode_ff == HUT_H5) || !uart_cts_n_in);
	assign txq.rready = tick && (tx_st_ff == HUT_S_IDLE) && can_send &&
		!pend_ff;

	always_comb
	begin
		enc_b = txq.rdata[7:0];
		enc_p = 8'h0;
		enc_pv = 1'b0;
		if (slip_on)
		begin
			if (txq.rdata[8])
				enc_b = HUT_SLIP_END;
			else if (txq.rdata[7:0] == HUT_SLIP_END)
			begin
				enc_b = HUT_SLIP_ESC;
				enc_p = HUT_ESC_END;
				enc_pv = 1'b1;
			end
			else if (txq.rdata[7:0] == HUT_SLIP_ESC)
			begin
				enc_b = HUT_SLIP_ESC;
				enc_p = HUT_ESC_ESC;
				enc_pv = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			tx_st_ff <= HUT_S_IDLE;
			tx_sub_ff <= 4'h0;
			tx_bit_ff <= 3'h0;
			tx_sh_ff <= 8'h0;
			tx_line_ff <= 1'b1;
			pend_ff <= 1'b0;
			pend_b_ff <= 8'h0;
		end
		else if (tick)
		begin
			tx_sub_ff <= tx_sub_ff + 4'h1;
			case (tx_st_ff)
				HUT_S_IDLE:
				begin
					tx_sub_ff <= 4'h0;
					tx_bit_ff <= 3'h0;
					if (can_send && (pend_ff || txq.rvalid))
					begin
						tx_st_ff <= HUT_S_START;
						tx_line_ff <= 1'b0;
						tx_sh_ff <= pend_ff ? pend_b_ff : enc_b;
						pend_ff <= !pend_ff && enc_pv;
						pend_b_ff <= enc_p;
					end
				end
				HUT_S_START:
					if (tx_sub_ff == HUT_OSR_LAST)
					begin
						tx_st_ff <= HUT_S_DATA;
						tx_line_ff <= tx_sh_ff[0];
					end
				HUT_S_DATA:
					if (tx_sub_ff == HUT_OSR_LAST)
					begin
						tx_bit_ff <= tx_bit_ff + 3'h1;
						tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
						tx_line_ff <= (tx_bit_ff == 3'h7) ? 1'b1 : tx_sh_ff[1];
						if (tx_bit_ff == 3'h7)
							tx_st_ff <= HUT_S_STOP;
					end
				HUT_S_STOP:
					if (tx_sub_ff == HUT_OSR_LAST)
						tx_st_ff <= HUT_S_IDLE;
				default: tx_st_ff <= HUT_S_IDLE;
			endcase
		end
	end
	assign uart_tx_out = tx_line_ff;

	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
			rts_n_ff <= 1'b0;
		else if (clk_en_in)
		begin
			if (mode_ff == HUT_H5)
				rts_n_ff <= 1'b0;
			else if (rxq.level >= LW'(RTS_HI))
				rts_n_ff <= 1'b1;
			else if (rxq.level <= LW'(RTS_LO))
				rts_n_ff <= 1'b0;
		end
	end
	assign uart_rts_n_out = rts_n_ff;
endmodule

// ---- core/hut_pkg.sv ----
// Constants, register map and types of the HCI UART transport.
// Assumes a 200 MHz core clock; imported by hut_uart and hut_fifo.
package hut_pkg;

	// ****************
	// Clock and timing
	// ****************
	localparam int HUT_CLK_PERIOD_PS = 5000;
	localparam logic [31:0] HUT_CLK_HZ =
		32'(64'd1000000000000 / HUT_CLK_PERIOD_PS);
	localparam logic [3:0] HUT_OSR_LAST = 4'hf;
	localparam logic [3:0] HUT_OSR_MID = 4'h7;

	// ****************
	// Register map
	// ****************
	localparam logic [7:0] HUT_OFF_CTRL = 8'h00;
	localparam logic [7:0] HUT_OFF_RATE = 8'h04;
	localparam logic [7:0] HUT_OFF_STAT = 8'h08;
	localparam logic [7:0] HUT_OFF_TXD = 8'h0c;
	localparam logic [7:0] HUT_OFF_RXD = 8'h10;
	localparam logic [7:0] HUT_OFF_LVL = 8'h14;
	localparam int HUT_CTRL_MODE = 0;
	localparam int HUT_CTRL_XON = 2;
	localparam int HUT_CTRL_SLIP = 3;
	localparam int HUT_CTRL_AB = 4;
	localparam int HUT_CTRL_SLEEP = 5;
	localparam int HUT_STAT_AB = 3;
	localparam int HUT_STAT_WAKE = 5;
	localparam int HUT_STAT_OVR = 6;
	localparam int HUT_RXD_VALID = 31;
	localparam logic [1:0] HUT_RESP_OKAY = 2'h0;
	localparam logic [1:0] HUT_RESP_SLVERR = 2'h2;

	// ****************
	// Line rates
	// ****************
	localparam logic [31:0] HUT_RATE_RESET = 32'd115385;
	localparam logic [31:0] HUT_RATE_MIN = 32'd9600;
	localparam logic [31:0] HUT_RATE_MAX = 32'd4000000;
	localparam logic [31:0] HUT_RATE_REQ [16] = '{
		32'd4000000, 32'd3692000, 32'd3000000, 32'd2000000,
		32'd1500000, 32'd1444444, 32'd921600, 32'd460800,
		32'd230400, 32'd115200, 32'd57600, 32'd38400,
		32'd28800, 32'd19200, 32'd14400, 32'd9600};
	localparam logic [31:0] HUT_RATE_ACT [16] = '{
		32'd4000000, 32'd3692308, 32'd3000000, 32'd2000000,
		32'd1500000, 32'd1454544, 32'd923077, 32'd461538,
		32'd230796, 32'd115385, 32'd57692, 32'd38400,
		32'd28846, 32'd19200, 32'd14423, 32'd9600};

	// ****************
	// Characters
	// ****************
	localparam logic [7:0] HUT_XON = 8'h11;
	localparam logic [7:0] HUT_XOFF = 8'h13;
	localparam logic [7:0] HUT_SLIP_END = 8'hc0;
	localparam logic [7:0] HUT_SLIP_ESC = 8'hdb;
	localparam logic [7:0] HUT_ESC_END = 8'hdc;
	localparam logic [7:0] HUT_ESC_ESC = 8'hdd;

	// ****************
	// Types
	// ****************
	typedef enum logic [1:0] {
		HUT_H4 = 2'b00,
		HUT_EH4 = 2'b01,
		HUT_H5 = 2'b10
	} hut_mode_t;
	typedef enum logic [1:0] {
		HUT_S_IDLE = 2'b00,
		HUT_S_START = 2'b01,
		HUT_S_DATA = 2'b10,
		HUT_S_STOP = 2'b11
	} hut_state_t;

endpackage

// ---- core/hut_fifo_if.sv ----
// Valid/ready carrier between a byte queue and its user.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface hut_fifo_if #(
	parameter int W = 9,
	parameter int LW = 11
);
	logic [W-1:0] wdata;
	logic wvalid;
	logic wready;
	logic [W-1:0] rdata;
	logic rvalid;
	logic rready;
	logic [LW-1:0] level;
	modport fill (input wdata, input wvalid, input rready,
		output wready, output rdata, output rvalid, output level);
	modport user (output wdata, output wvalid, output rready,
		input wready, input rdata, input rvalid, input level);
endinterface

// ---- core/hut_fifo.sv ----
// Flip-flop queue with valid/ready on both sides.
// Assumes the user honours wready and rvalid.
`timescale 1ns/1ps
module hut_fifo
	import hut_pkg::*;
#(
	parameter int W = 9,
	parameter int DEPTH = 1040,
	parameter int LW = 11
)(
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	hut_fifo_if.fill q
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [LW-1:0] level_ff;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] nxt_ptr(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign q.wready = (level_ff != LW'(DEPTH));
	assign q.rvalid = (level_ff != '0);
	assign q.rdata = mem_ff[rd_ptr_ff];
	assign q.level = level_ff;
	assign push = clk_en_in && q.wvalid && q.wready;
	assign pop = clk_en_in && q.rready && q.rvalid;

	always_ff @(posedge clock_in)
	begin
		if (push)
			mem_ff[wr_ptr_ff] <= q.wdata;
	end

	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			level_ff <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_ff <= nxt_ptr(wr_ptr_ff);
			if (pop)
				rd_ptr_ff <= nxt_ptr(rd_ptr_ff);
			if (push && !pop)
				level_ff <= level_ff + 1'b1;
			else if (pop && !push)
				level_ff <= level_ff - 1'b1;
		end
	end
endmodule

// ---- verification/hut_props.sv ----
// Concurrent checks on the HCI UART transport top ports.
// Assumes one clock domain; bound to every hut_uart instance.
`timescale 1ns/1ps
module hut_props
	import hut_pkg::*;
(
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic uart_tx_out,
	input wire logic uart_rts_n_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	logic prev_ff;
	logic [7:0] run_ff;
	// Starts saturated so an early start bit is not a short run
	always_ff @(posedge clock_in)
	begin
		prev_ff <= uart_tx_out;
		if (sys_rst_in)
			run_ff <= 8'hff;
		else if (uart_tx_out != prev_ff)
			run_ff <= 8'h00;
		else if (run_ff != 8'hff)
			run_ff <= run_ff + 8'h01;
	end
	a_bit_width: assert property (uart_tx_out != prev_ff
		|-> run_ff >= 8'd40)
		else $error("serial level held shorter than one bit");
	a_write_resp: assert property (s_axi_awvalid_in && s_axi_awready_out
		&& s_axi_wvalid_in && s_axi_wready_out && !s_axi_bvalid_out
		##1 clk_en_in |=> s_axi_bvalid_out)
		else $error("write response late");
	a_read_resp: assert property (s_axi_arvalid_in && s_axi_arready_out
		|=> s_axi_rvalid_out)
		else $error("read data late");
	a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
		|=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
		|=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read data dropped");
	a_bresp_once: assert property (s_axi_bvalid_out && s_axi_bready_in
		|=> !s_axi_bvalid_out)
		else $error("write response repeated");
	a_ar_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read taken while data pending");
	a_enable_gate: assert property (!clk_en_in |-> !(s_axi_awready_out
		|| s_axi_wready_out || s_axi_arready_out))
		else $error("ready while disabled");
	a_pins_reset: assert property ($past(sys_rst_in)
		|-> uart_tx_out && !uart_rts_n_out)
		else $error("serial pins wrong after reset");
	cover property (s_axi_bvalid_out && s_axi_bresp_out == HUT_RESP_SLVERR);
	cover property ($rose(uart_rts_n_out));
	cover property ($fell(uart_tx_out));
endmodule
bind hut_uart hut_props hut_props_i (.*);

// ---- verification/hut_host.sv ----
// Host UART model: drives the device receive line, decodes its output.
// Assumes one clock; the bench sets the bit length in clocks.
`timescale 1ns/1ps
module hut_host
(
	input wire logic clock_in,
	input wire logic tx_in,
	input wire logic rts_n_in,
	output logic rx_out
);
	int bit_clk = 1733;
	logic [7:0] got[$];
	initial rx_out = 1'b1;
	// Mid-bit sampling tolerates the fractional rate jitter
	initial
	forever
	begin : decode
		logic [7:0] b;
		@(negedge tx_in);
		repeat (bit_clk / 2) @(posedge clock_in);
		repeat (8)
		begin
			repeat (bit_clk) @(posedge clock_in);
			b = {tx_in, b[7:1]};
		end
		repeat (bit_clk) @(posedge clock_in);
		got.push_back(b);
	end
	task automatic send(input logic [7:0] b);
		int i;
		for (i = 0; i < 9999 && rts_n_in; i++)
			@(posedge clock_in);
		if (i == 9999)
			tb_top.lost;
		for (i = 0; i < 10; i++)
		begin
			rx_out <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
			repeat (bit_clk) @(posedge clock_in);
		end
	endtask
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the HCI UART transport.
// Assumes hut_props is bound and hut_host sits on the serial side.
`timescale 1ns/1ps
module tb_top
	import hut_pkg::*;
;
	logic clock_in, sys_rst_in, clk_en_in;
	logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rv;
	logic [3:0] s_axi_wstrb_in;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rsp, bsp;
	logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
	logic s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
	logic s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out;
	logic s_axi_rready_in, uart_rx_in, uart_tx_out, uart_cts_n_in;
	logic uart_rts_n_out;
	int fails, n_checks, k;
	hut_uart #(.QDEPTH(16), .RTS_HI(12), .RTS_LO(8)) hut_uart_i (.*);
	hut_host hut_host_i (.clock_in(clock_in), .tx_in(uart_tx_out),
		.rts_n_in(uart_rts_n_out), .rx_out(uart_rx_in));
	initial
	begin
		clock_in = 1'b0;
		forever #2.5 clock_in = ~clock_in;
	end
	task automatic final_report;
		if (fails == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic lost;
		fails++;
		final_report;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_checks++;
		if (s !== e)
		begin
			fails++;
			$display("wrong value %s: expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		for (i = 0; i < 400; i++)
		begin
			@(posedge clock_in);
			s_axi_bready_in <= !s_axi_bvalid_out;
			if (s_axi_awready_out)
				s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out)
				s_axi_wvalid_in <= 1'b0;
			if (s_axi_bvalid_out)
				break;
		end
		bsp = s_axi_bresp_out;
		if (i == 400)
			lost;
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		int i;
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		for (i = 0; i < 400; i++)
		begin
			@(posedge clock_in);
			s_axi_rready_in <= !s_axi_rvalid_out;
			if (s_axi_arready_out)
				s_axi_arvalid_in <= 1'b0;
			if (s_axi_rvalid_out)
				break;
		end
		rv = s_axi_rdata_out;
		rsp = s_axi_rresp_out;
		if (i == 400)
			lost;
		chk(nm, rv, e);
	endtask
	task automatic tx_wait(input int n, input logic [7:0] e);
		int i;
		for (i = 0; i < 40000 && hut_host_i.got.size() < n; i++)
			@(posedge clock_in);
		if (i == 40000)
			lost;
		chk("tx byte", 32'(hut_host_i.got.pop_front()), 32'(e));
	endtask
	task automatic t_reset;
		rc("ctrl", HUT_OFF_CTRL, 32'h0);
		rc("rate", HUT_OFF_RATE, 32'd115385);
		rc("status", HUT_OFF_STAT, 32'h2);
		rc("hole", 8'h18, 32'h0);
		chk("hole rresp", 32'(rsp), 32'(HUT_RESP_SLVERR));
		wr(8'h18, 32'h1);
		chk("hole bresp", 32'(bsp), 32'(HUT_RESP_SLVERR));
		wr(HUT_OFF_TXD, 32'h55);
		tx_wait(1, 8'h55);
	endtask
	task automatic t_rates;
		for (k = 0; k < 16; k++)
		begin
			wr(HUT_OFF_RATE, HUT_RATE_REQ[k]);
			rc("rate", HUT_OFF_RATE, HUT_RATE_ACT[k]);
		end
		wr(HUT_OFF_RATE, 32'd5000000);
		rc("rate max", HUT_OFF_RATE, 32'd4000000);
		wr(HUT_OFF_RATE, 32'd100);
		rc("rate min", HUT_OFF_RATE, 32'd9600);
		wr(HUT_OFF_RATE, 32'd4000000);
		hut_host_i.bit_clk = 50;
	endtask
	task automatic t_data;
		s_axi_wstrb_in <= 4'he;
		wr(HUT_OFF_TXD, 32'h99);
		s_axi_wstrb_in <= 4'hf;
		wr(HUT_OFF_TXD, 32'h5a);
		wr(HUT_OFF_TXD, 32'ha5);
		tx_wait(1, 8'h5a);
		tx_wait(1, 8'ha5);
		hut_host_i.send(8'h3c);
		hut_host_i.send(8'hc3);
		rc("level", HUT_OFF_LVL, 32'h2);
		rc("rx 1", HUT_OFF_RXD, 32'h8000003c);
		rc("rx 2", HUT_OFF_RXD, 32'h800000c3);
		rc("rx empty", HUT_OFF_STAT, 32'h2);
	endtask
	task automatic t_flow;
		wr(HUT_OFF_CTRL, 32'h4);
		hut_host_i.send(HUT_XOFF);
		rc("paused", HUT_OFF_STAT, 32'h6);
		wr(HUT_OFF_TXD, 32'h77);
		// Two whole frames at 50 clocks a bit
		repeat (1000) @(posedge clock_in);
		chk("held", 32'(hut_host_i.got.size()), 32'h0);
		hut_host_i.send(HUT_XON);
		tx_wait(1, 8'h77);
		rc("resumed", HUT_OFF_STAT, 32'h2);
		uart_cts_n_in <= 1'b1;
		wr(HUT_OFF_TXD, 32'h42);
		repeat (1000) @(posedge clock_in);
		chk("cts", 32'(hut_host_i.got.size()), 32'h0);
		wr(HUT_OFF_CTRL, 32'ha);
		tx_wait(1, 8'h42);
	endtask
	task automatic t_slip;
		hut_host_i.send(HUT_SLIP_ESC);
		hut_host_i.send(HUT_ESC_END);
		hut_host_i.send(HUT_SLIP_END);
		rc("unescaped", HUT_OFF_RXD, 32'h800000c0);
		rc("delimiter", HUT_OFF_RXD, 32'h800001c0);
		wr(HUT_OFF_TXD, 32'h100);
		wr(HUT_OFF_TXD, 32'hc0);
		tx_wait(1, 8'hc0);
		tx_wait(1, 8'hdb);
		tx_wait(1, 8'hdc);
		wr(HUT_OFF_CTRL, 32'h20);
		rc("asleep", HUT_OFF_STAT, 32'h12);
		uart_cts_n_in <= 1'b0;
		repeat (8) @(posedge clock_in);
		rc("woken", HUT_OFF_STAT, 32'h22);
		wr(HUT_OFF_STAT, 32'h20);
		rc("w1c", HUT_OFF_STAT, 32'h2);
	endtask
	task automatic t_detect;
		wr(HUT_OFF_CTRL, 32'h10);
		rc("armed", HUT_OFF_CTRL, 32'h10);
		hut_host_i.bit_clk = 100;
		hut_host_i.send(8'hff);
		rc("found", HUT_OFF_STAT, 32'h30a);
		rc("new rate", HUT_OFF_RATE, 32'd2000000);
		hut_host_i.send(8'h66);
		rc("after", HUT_OFF_RXD, 32'h80000066);
		for (k = 0; k < 12; k++)
			hut_host_i.send(8'(k));
		@(posedge clock_in);
		chk("rts high", 32'(uart_rts_n_out), 32'h1);
		for (k = 0; k < 4; k++)
			rc("drain", HUT_OFF_RXD, 32'h80000000 | k);
		@(posedge clock_in);
		chk("rts low", 32'(uart_rts_n_out), 32'h0);
	endtask
	initial
	begin
		sys_rst_in = 1'b1;
		clk_en_in = 1'b1;
		s_axi_wstrb_in = 4'hf;
		uart_cts_n_in = 1'b0;
		{s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = '0;
		{s_axi_arvalid_in, s_axi_rready_in, fails, n_checks} = '0;
		repeat (5) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		clk_en_in <= 1'b0;
		repeat (3) @(posedge clock_in);
		clk_en_in <= 1'b1;
		@(posedge clock_in);
		t_reset;
		t_rates;
		t_data;
		t_flow;
		t_slip;
		t_detect;
		final_report;
	end
endmodule
